// File: pcs_sequencer.sv
// Proximity measurement cycle sequencer with register file and interrupt.
`timescale 1ns/1ps
// How it works
// - Signed offset register is added to each measurement before storing.
// - Valid flag sets after first cycle, stays until sensing disabled.
// - Interrupt status always kept; output pin only when output enable set.
// - Sixteen-bit lower and upper limits; outside either is out of range.
// - Lower limit checked first; upper ignored when lower exceeds it.
// - Interrupt only after programmed count of consecutive out-of-range results.
// - Interrupt stays set until host sends the clear command.
// - Sensing runs init, LED accumulation, fixed wait, then conversion.
// - Init and post-accumulation wait last one fixed 2.73 ms step.
// - Accumulation length from pulse count, conversion from conversion field.
// - Each LED pulse is 7.3 us on then 8.7 us off.
// - Interrupt asserted at end of conversion; then sleep if enabled.
// - Wait state follows sensing only when wait is enabled.
// - Long wait multiplies the wait duration by twelve.
// - Wait lasts (256 minus wait field) steps of 2.73 ms.
// - Bus start leaves sleep only with power bit set; returns to sleep if power bit clear.
// - New cycle starts automatically while power and sensing stay enabled.
// - Each result stored as sixteen bits across two byte registers.
// - After interrupt sleep, stay asleep until the host accesses the bus.
module pcs_sequencer #(
	parameter int STEP_CYCLES = pcs_pkg::STEP_CYCLES
) (
	input  wire logic                 ref_clk,
	input  wire logic                 reset_n,
	input  wire pcs_pkg::pcs_reg_req_t reg_req,
	input  wire logic                 irq_clear,
	input  wire logic                 bus_start,
	input  wire logic [15:0]          adc_count,
	output logic      [7:0]           reg_rdata,
	output logic                      led_drive,
	output logic                      irq_out,
	output logic                      sleep_mode
);
	import pcs_pkg::*;

	localparam int CW = $clog2(STEP_CYCLES + ON_CYCLES + OFF_CYCLES + 1);
	localparam logic [CW-1:0] STEP_LOAD = CW'(STEP_CYCLES - 1);
	localparam logic [CW-1:0] ON_LOAD   = CW'(ON_CYCLES - 1);
	localparam logic [CW-1:0] OFF_LOAD  = CW'(OFF_CYCLES - 1);

	logic [7:0]  function_enable;
	logic [7:0]  conversion_time_field;
	logic [7:0]  wait_time_field;
	logic [15:0] lower_limit;
	logic [15:0] upper_limit;
	logic [7:0]  interrupt_persistence;
	logic [7:0]  config_reg;
	logic [7:0]  led_pulse_count;
	logic [7:0]  result_offset;
	logic [15:0] measurement_result;
	logic        result_valid_flag;
	logic        irq_pending;
	logic [3:0]  interrupt_persistence_run;

	pcs_state_t  state;
	pcs_state_t  next_state;
	logic [CW-1:0] phase_cnt;
	logic [11:0] step_cnt;
	logic [11:0] next_steps;
	logic        led_on;

	logic power_on_bit, sensing_enable, wait_enable, irq_output_enable;
	logic sleep_after_irq, long_wait;
	logic [3:0]  persistence_count;
	logic [17:0] offset_sum;
	logic [15:0] adjusted;
	logic        below_low, above_high, out_of_range, irq_fire;
	logic        seg_end, conv_done;

	assign power_on_bit      = function_enable[EN_PON];
	assign sensing_enable    = function_enable[EN_SENSE];
	assign wait_enable       = function_enable[EN_WAIT];
	assign irq_output_enable = function_enable[EN_IRQ];
	assign sleep_after_irq   = function_enable[EN_SAI];
	assign long_wait         = config_reg[CFG_LONG];
	assign persistence_count = interrupt_persistence[INTERRUPT_PERSISTENCE_LSB +: 4];

	// Offset can push the result past either end, so it is clamped
	always_comb begin
		offset_sum = {2'b00, adc_count} + {{10{result_offset[7]}}, result_offset};
		if (offset_sum[17]) begin
			adjusted = 16'h0000;
		end else if (offset_sum[16]) begin
			adjusted = 16'hffff;
		end else begin
			adjusted = offset_sum[15:0];
		end
	end

	always_comb begin
		below_low    = adjusted < lower_limit;
		above_high   = (lower_limit <= upper_limit) && (adjusted > upper_limit);
		out_of_range = below_low || above_high;
		// A persistence of zero fires on every out-of-range result
		irq_fire     = out_of_range && (({1'b0, interrupt_persistence_run} + 5'h01) >= {1'b0, persistence_count});
	end

	assign seg_end   = (phase_cnt == '0) && (step_cnt == 12'h000)
		&& !(state == ST_ACCUM && led_on);
	assign conv_done = (state == ST_CONV) && seg_end && power_on_bit && sensing_enable;

	always_comb begin
		next_state = state;
		unique case (state)
			ST_SLEEP: begin
				if (bus_start && power_on_bit) begin
					next_state = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (!power_on_bit) begin
					next_state = ST_SLEEP;
				end else if (sensing_enable) begin
					next_state = ST_INIT;
				end
			end
			ST_WAIT: begin
				if (!power_on_bit || seg_end) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				if (!power_on_bit || !sensing_enable) begin
					next_state = ST_IDLE;
				end else if (seg_end) begin
					unique case (state)
						ST_INIT: begin
							next_state = (led_pulse_count == RST_ZERO) ? ST_PWAIT : ST_ACCUM;
						end
						ST_ACCUM: begin
							next_state = ST_PWAIT;
						end
						ST_PWAIT: begin
							next_state = ST_CONV;
						end
						default: begin
							if (irq_fire && sleep_after_irq) begin
								next_state = ST_SLEEP;
							end else if (wait_enable) begin
								next_state = ST_WAIT;
							end else begin
								next_state = ST_IDLE;
							end
						end
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= ST_SLEEP;
		end else begin
			state <= next_state;
		end
	end

	// Step counts for the segment being entered
	always_comb begin
		unique case (next_state)
			ST_ACCUM: next_steps = {4'h0, led_pulse_count} - 12'h001;
			ST_CONV:  next_steps = 12'(STEP_SPAN - {1'b0, conversion_time_field}) - 12'h001;
			ST_WAIT: begin
				if (long_wait) begin
					next_steps = 12'(12'(STEP_SPAN - {1'b0, wait_time_field}) * LONG_MULT)
						- 12'h001;
				end else begin
					next_steps = 12'(STEP_SPAN - {1'b0, wait_time_field}) - 12'h001;
				end
			end
			default:  next_steps = 12'h000;
		endcase
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			phase_cnt <= '0;
			step_cnt  <= 12'h000;
			led_on    <= 1'b0;
		end else if (next_state != state) begin
			step_cnt  <= next_steps;
			led_on    <= (next_state == ST_ACCUM);
			phase_cnt <= (next_state == ST_ACCUM) ? ON_LOAD : STEP_LOAD;
		end else if (phase_cnt != '0) begin
			phase_cnt <= phase_cnt - CW'(1);
		end else if (state == ST_ACCUM && led_on) begin
			led_on    <= 1'b0;
			phase_cnt <= OFF_LOAD;
		end else if (step_cnt != 12'h000) begin
			step_cnt  <= step_cnt - 12'h001;
			led_on    <= (state == ST_ACCUM);
			phase_cnt <= (state == ST_ACCUM) ? ON_LOAD : STEP_LOAD;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			measurement_result <= 16'h0000;
			interrupt_persistence_run           <= 4'h0;
		end else if (conv_done) begin
			measurement_result <= adjusted;
			if (!out_of_range) begin
				interrupt_persistence_run <= 4'h0;
			end else if (interrupt_persistence_run != 4'hf) begin
				interrupt_persistence_run <= interrupt_persistence_run + 4'h1;
			end
		end
	end

	// Hardware set takes priority over a clear arriving in the same cycle
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_pending <= 1'b0;
		end else if (conv_done && irq_fire) begin
			irq_pending <= 1'b1;
		end else if (irq_clear) begin
			irq_pending <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			result_valid_flag <= 1'b0;
		end else if (conv_done) begin
			result_valid_flag <= 1'b1;
		end else if (!sensing_enable) begin
			result_valid_flag <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_out    <= 1'b0;
			led_drive  <= 1'b0;
			sleep_mode <= 1'b1;
		end else begin
			irq_out    <= irq_pending && irq_output_enable;
			led_drive  <= led_on && (state == ST_ACCUM);
			sleep_mode <= (state == ST_SLEEP);
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			function_enable       <= RST_ZERO;
			conversion_time_field <= RST_TIME;
			wait_time_field       <= RST_TIME;
			lower_limit           <= {RST_ZERO, RST_ZERO};
			upper_limit           <= {RST_ZERO, RST_ZERO};
			interrupt_persistence <= RST_ZERO;
			config_reg            <= RST_ZERO;
			led_pulse_count       <= RST_ZERO;
			result_offset         <= RST_ZERO;
		end else if (reg_req.wr) begin
			unique case (reg_req.addr)
				ADDR_ENABLE:  function_enable       <= reg_req.wdata;
				ADDR_CONVT:   conversion_time_field <= reg_req.wdata;
				ADDR_WAITT:   wait_time_field       <= reg_req.wdata;
				ADDR_LOWL:    lower_limit[7:0]      <= reg_req.wdata;
				ADDR_LOWH:    lower_limit[15:8]     <= reg_req.wdata;
				ADDR_UPPL:    upper_limit[7:0]      <= reg_req.wdata;
				ADDR_UPPH:    upper_limit[15:8]     <= reg_req.wdata;
				ADDR_PERSIST: interrupt_persistence <= reg_req.wdata;
				ADDR_CONFIG:  config_reg            <= reg_req.wdata;
				ADDR_PULSES:  led_pulse_count       <= reg_req.wdata;
				ADDR_OFFSET:  result_offset         <= reg_req.wdata;
				default: ;
			endcase
		end
	end

	// Unmapped addresses read back as zero
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= RST_ZERO;
		end else if (reg_req.rd) begin
			unique case (reg_req.addr)
				ADDR_ENABLE:  reg_rdata <= function_enable;
				ADDR_CONVT:   reg_rdata <= conversion_time_field;
				ADDR_WAITT:   reg_rdata <= wait_time_field;
				ADDR_LOWL:    reg_rdata <= lower_limit[7:0];
				ADDR_LOWH:    reg_rdata <= lower_limit[15:8];
				ADDR_UPPL:    reg_rdata <= upper_limit[7:0];
				ADDR_UPPH:    reg_rdata <= upper_limit[15:8];
				ADDR_PERSIST: reg_rdata <= interrupt_persistence;
				ADDR_CONFIG:  reg_rdata <= config_reg;
				ADDR_PULSES:  reg_rdata <= led_pulse_count;
				ADDR_STATUS: begin
					reg_rdata <= RST_ZERO;
					reg_rdata[ST_VALID] <= result_valid_flag;
					reg_rdata[ST_INT]   <= irq_pending;
				end
				ADDR_RESL:    reg_rdata <= measurement_result[7:0];
				ADDR_RESH:    reg_rdata <= measurement_result[15:8];
				ADDR_OFFSET:  reg_rdata <= result_offset;
				default:      reg_rdata <= RST_ZERO;
			endcase
		end
	end

	chk_valid_drops: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!sensing_enable && !conv_done |=> !result_valid_flag)
		else $error("valid flag kept while sensing disabled");
	chk_irq_gating: assert property (@(posedge ref_clk) disable iff (!reset_n)
		irq_out |-> $past(irq_pending) && $past(irq_output_enable))
		else $error("interrupt pin driven without enable");
	chk_low_first: assert property (@(posedge ref_clk) disable iff (!reset_n)
		lower_limit > upper_limit && adjusted >= lower_limit |-> !out_of_range)
		else $error("upper limit used while below lower");
	chk_irq_sticky: assert property (@(posedge ref_clk) disable iff (!reset_n)
		irq_pending && !irq_clear |=> irq_pending)
		else $error("interrupt dropped without clear");
	chk_accum_next: assert property (@(posedge ref_clk) disable iff (!reset_n)
		state == ST_ACCUM ##1 state != ST_ACCUM && state != ST_IDLE |-> state == ST_PWAIT)
		else $error("accumulation not followed by fixed wait");
	chk_led_accum: assert property (@(posedge ref_clk) disable iff (!reset_n)
		$rose(led_drive) |-> $past(state, 1) == ST_ACCUM ##[1:913] !led_drive)
		else $error("LED pulse wrong");
	chk_sai_sleep: assert property (@(posedge ref_clk) disable iff (!reset_n)
		conv_done && irq_fire && sleep_after_irq |=> state == ST_SLEEP && irq_pending)
		else $error("no sleep after interrupt");
	chk_wait_skip: assert property (@(posedge ref_clk) disable iff (!reset_n)
		state == ST_CONV && !wait_enable |=> state != ST_WAIT)
		else $error("wait entered while disabled");
	chk_sleep_stay: assert property (@(posedge ref_clk) disable iff (!reset_n)
		state == ST_SLEEP && !(bus_start && power_on_bit) |=> state == ST_SLEEP)
		else $error("sleep left without start");
	chk_interrupt_persistence_reset: assert property (@(posedge ref_clk) disable iff (!reset_n)
		conv_done && !out_of_range |=> interrupt_persistence_run == 4'h0)
		else $error("persistence not restarted");
	chk_valid_sets: assert property (@(posedge ref_clk) disable iff (!reset_n)
		conv_done |=> result_valid_flag)
		else $error("valid flag not set after cycle");
	chk_irq_at_conv: assert property (@(posedge ref_clk) disable iff (!reset_n)
		$rose(irq_pending) |-> $past(conv_done))
		else $error("interrupt raised outside conversion end");
	chk_cycle_restart: assert property (@(posedge ref_clk) disable iff (!reset_n)
		state == ST_IDLE && power_on_bit && sensing_enable |=> state == ST_INIT)
		else $error("new cycle not started");
endmodule : pcs_sequencer

// File: pcs_pkg.sv
// Shared constants and types for the proximity cycle sequencer.
package pcs_pkg;
	// Register addresses (5-bit command address space)
	localparam logic [4:0] ADDR_ENABLE  = 5'h00;
	localparam logic [4:0] ADDR_CONVT   = 5'h02;
	localparam logic [4:0] ADDR_WAITT   = 5'h03;
	localparam logic [4:0] ADDR_LOWL    = 5'h08;
	localparam logic [4:0] ADDR_LOWH    = 5'h09;
	localparam logic [4:0] ADDR_UPPL    = 5'h0a;
	localparam logic [4:0] ADDR_UPPH    = 5'h0b;
	localparam logic [4:0] ADDR_PERSIST = 5'h0c;
	localparam logic [4:0] ADDR_CONFIG  = 5'h0d;
	localparam logic [4:0] ADDR_PULSES  = 5'h0e;
	localparam logic [4:0] ADDR_STATUS  = 5'h13;
	localparam logic [4:0] ADDR_RESL    = 5'h18;
	localparam logic [4:0] ADDR_RESH    = 5'h19;
	localparam logic [4:0] ADDR_OFFSET  = 5'h1e;
	// Field positions
	localparam int EN_PON   = 0;
	localparam int EN_SENSE = 2;
	localparam int EN_WAIT  = 3;
	localparam int EN_IRQ   = 5;
	localparam int EN_SAI   = 6;
	localparam int CFG_LONG = 1;
	localparam int ST_VALID = 1;
	localparam int ST_INT   = 5;
	localparam int INTERRUPT_PERSISTENCE_LSB = 4;
	// Reset values
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_TIME = 8'hff;
	// Timing: one 2.73 ms step, LED on 7.3 us, LED off 8.7 us, at 125 MHz
	localparam int CLK_MHZ     = 125;
	localparam int STEP_NS     = 2730000;
	localparam int LED_ON_NS   = 7300;
	localparam int LED_OFF_NS  = 8700;
	localparam int STEP_CYCLES = (STEP_NS * CLK_MHZ + 999) / 1000;
	localparam int ON_CYCLES   = (LED_ON_NS * CLK_MHZ + 999) / 1000;
	localparam int OFF_CYCLES  = (LED_OFF_NS * CLK_MHZ + 999) / 1000;
	localparam logic [8:0]  STEP_SPAN = 9'h100;
	localparam logic [11:0] LONG_MULT = 12'h00c;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [4:0] addr;
		logic [7:0] wdata;
	} pcs_reg_req_t;

	typedef enum logic [2:0] {
		ST_SLEEP = 3'b000,
		ST_IDLE  = 3'b001,
		ST_INIT  = 3'b010,
		ST_ACCUM = 3'b011,
		ST_PWAIT = 3'b100,
		ST_CONV  = 3'b101,
		ST_WAIT  = 3'b110
	} pcs_state_t;
endpackage : pcs_pkg

// File: pcs_host_model.sv
// Host-side model: decoded register requests, interrupt clear and bus start.
`timescale 1ns/1ps
module pcs_host_model (
	input  wire logic             ref_clk,
	output pcs_pkg::pcs_reg_req_t reg_req,
	output logic                  irq_clear,
	output logic                  bus_start
);
	import pcs_pkg::*;

	initial begin
		reg_req = '0;
		irq_clear = 1'b0;
		bus_start = 1'b0;
	end

	// One request per call, held across exactly one rising edge
	task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		reg_req = '{wr: w, rd: !w, addr: a, wdata: d};
		@(negedge ref_clk);
		reg_req = '0;
	endtask : xfer

	task automatic pulse(input logic clr);
		@(negedge ref_clk);
		if (clr)
			irq_clear = 1'b1;
		else
			bus_start = 1'b1;
		@(negedge ref_clk);
		irq_clear = 1'b0;
		bus_start = 1'b0;
	endtask : pulse
endmodule : pcs_host_model

// File: tb_top.sv
// Self-checking bench for the proximity cycle sequencer.
`timescale 1ns/1ps
module tb_top;
	import pcs_pkg::*;
	// Short step keeps the run small; the wait, long-wait and conversion span checks derive from it
	localparam int STEP = 50;
	logic         ref_clk;
	logic         reset_n;
	logic [15:0]  adc_count;
	pcs_reg_req_t reg_req;
	logic         irq_clear;
	logic         bus_start;
	logic [7:0]   reg_rdata;
	logic         led_drive;
	logic         irq_out;
	logic         sleep_mode;
	int           fail_count = 0;
	int           samples_checked = 0;
	int           n;
	int           p0;
	int           p1;

	pcs_host_model host (.ref_clk(ref_clk), .reg_req(reg_req), .irq_clear(irq_clear),
		.bus_start(bus_start));
	pcs_sequencer #(.STEP_CYCLES(STEP)) uut (.ref_clk(ref_clk), .reset_n(reset_n),
		.reg_req(reg_req), .irq_clear(irq_clear), .bus_start(bus_start),
		.adc_count(adc_count), .reg_rdata(reg_rdata), .led_drive(led_drive),
		.irq_out(irq_out), .sleep_mode(sleep_mode));

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic summarize;
		if (fail_count == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		host.xfer(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [4:0] a, input logic [7:0] e, input string w);
		host.xfer(1'b0, a, 8'h00);
		@(negedge ref_clk);
		check(w, reg_rdata, e);
	endtask : rd

	// Cycles seen at one LED level from the current sample on
	task automatic span(input logic lv, output int c);
		c = 0;
		while (led_drive === lv && c < 40000) begin
			@(negedge ref_clk);
			c++;
		end
	endtask : span

	// A LED rise marks the start of each new cycle's accumulation
	task automatic rise(output int c);
		int a;
		span(1'b1, a);
		span(1'b0, c);
		c += a;
	endtask : rise

	// Raw count for the cycle under way, then the stored result on the next rise
	task automatic measure(input logic [15:0] raw, input logic [15:0] want, input string w);
		adc_count = raw;
		rise(n);
		rd(ADDR_RESL, want[7:0], w);
		rd(ADDR_RESH, want[15:8], w);
	endtask : measure

	initial begin
		#(8 * 100000);
		fail_count++;
		summarize();
	end

	initial begin
		reset_n = 1'b0;
		adc_count = 16'h0005;
		repeat (8) @(negedge ref_clk);
		reset_n = 1'b1;
		rd(ADDR_ENABLE, RST_ZERO, "enable");
		rd(ADDR_CONVT, RST_TIME, "conv_time");
		rd(ADDR_WAITT, RST_TIME, "wait_time");
		rd(ADDR_STATUS, RST_ZERO, "status_rst");
		rd(5'h1f, 8'h00, "unmapped");
		check("sleep_rst", sleep_mode, 1'b1);
		wr(ADDR_OFFSET, 8'hfe);
		rd(ADDR_OFFSET, 8'hfe, "offset_rw");
		wr(ADDR_LOWL, 8'h10);
		wr(ADDR_UPPH, 8'h01);
		wr(ADDR_PERSIST, 8'h20);
		wr(ADDR_PULSES, 8'h02);
		wr(ADDR_ENABLE, 8'h25);
		host.pulse(1'b0);
		rise(n);
		span(1'b1, n);
		check("led_on", n, ON_CYCLES);
		span(1'b0, n);
		check("led_off", n, OFF_CYCLES);
		wr(ADDR_PULSES, 8'h01);
		rise(n);
		rd(ADDR_RESL, 8'h03, "res_lo");
		rd(ADDR_RESH, 8'h00, "res_hi");
		rd(ADDR_STATUS, 8'h02, "status_one");
		check("irq_one", irq_out, 1'b0);
		rise(n);
		rd(ADDR_STATUS, 8'h22, "status_two");
		check("irq_two", irq_out, 1'b1);
		wr(ADDR_ENABLE, 8'h05);
		rd(ADDR_STATUS, 8'h22, "status_gated");
		check("irq_gated", irq_out, 1'b0);
		wr(ADDR_ENABLE, 8'h25);
		adc_count = 16'h0050;
		rise(n);
		check("irq_held", irq_out, 1'b1);
		host.pulse(1'b1);
		rise(n);
		check("irq_cleared", irq_out, 1'b0);
		adc_count = 16'h0005;
		rise(n);
		adc_count = 16'h0050;
		rise(n);
		adc_count = 16'h0005;
		rise(n);
		check("irq_broken_run", irq_out, 1'b0);
		rise(n);
		check("irq_run", irq_out, 1'b1);
		wr(ADDR_PERSIST, 8'h00);
		wr(ADDR_LOWL, 8'h00);
		wr(ADDR_LOWH, 8'h02);
		adc_count = 16'h0300;
		rise(n);
		host.pulse(1'b1);
		rise(n);
		check("irq_upper_ignored", irq_out, 1'b0);
		wr(ADDR_LOWH, 8'h00);
		rise(n);
		check("irq_upper", irq_out, 1'b1);
		rise(n);
		rise(p0);
		wr(ADDR_ENABLE, 8'h2d);
		rise(n);
		rise(p1);
		check("wait_span", p1 - p0, STEP);
		wr(ADDR_CONFIG, 8'h02);
		rise(n);
		rise(p1);
		check("long_wait", p1 - p0, 12 * STEP);
		wr(ADDR_ENABLE, 8'h25);
		wr(ADDR_CONFIG, 8'h00);
		wr(ADDR_CONVT, 8'hfe);
		rise(n);
		rise(p1);
		check("conv_span", p1 - p0, STEP);
		wr(ADDR_CONVT, 8'hff);
		wr(ADDR_OFFSET, 8'h05);
		measure(16'hfffe, 16'hffff, "clamp_high");
		wr(ADDR_OFFSET, 8'hfe);
		measure(16'h0001, 16'h0000, "clamp_low");
		adc_count = 16'h0300;
		host.pulse(1'b1);
		wr(ADDR_ENABLE, 8'h65);
		n = 0;
		while (sleep_mode !== 1'b1 && n < 5000) begin
			@(negedge ref_clk);
			n++;
		end
		check("irq_sleep", irq_out, 1'b1);
		n = 0;
		repeat (3000) begin
			@(negedge ref_clk);
			if (led_drive !== 1'b0 || sleep_mode !== 1'b1)
				n++;
		end
		check("sleep_hold", n, 0);
		host.pulse(1'b1);
		host.pulse(1'b0);
		repeat (4) @(negedge ref_clk);
		check("wake", sleep_mode, 1'b0);
		wr(ADDR_ENABLE, 8'h00);
		host.pulse(1'b0);
		repeat (4) @(negedge ref_clk);
		check("back_to_sleep", sleep_mode, 1'b1);
		rd(ADDR_STATUS, 8'h00, "valid_off");
		reset_n = 1'b0;
		repeat (2) @(negedge ref_clk);
		reset_n = 1'b1;
		rd(ADDR_OFFSET, RST_ZERO, "offset_rst");
		check("sleep_rst2", sleep_mode, 1'b1);
		summarize();
	end
endmodule : tb_top
